// *** etdt_mem_model.sv ***
// ****************************************
// memory partner: byte array, big-endian words
// ****************************************
module etdt_mem_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire etdt_pkg::etdt_mem_cmd_t cmd,
    input wire logic [1:0] delay,
    output logic [15:0] rdata,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ns;
    import etdt_pkg::*;
    logic [7:0] mem [0:65535];
    logic [1:0] cnt;
    always @(posedge clk) begin
        if (sys_rst) begin
            ack <= 1'h0;
            cnt <= 2'h0;
            rdata <= 16'h0000;
        end else if (ack || !cmd.req) begin
            // released bus inverts rdata each cycle, so stale data never holds steady
            ack <= 1'h0;
            cnt <= 2'h0;
            rdata <= ~rdata;
        end else if (cnt != delay) begin
            cnt <= cnt + 2'h1;
            rdata <= ~rdata;
        end else begin
            ack <= 1'h1;
            if (cmd.we && cmd.word) begin
                mem[cmd.addr] <= cmd.wdata[15:8];
                mem[cmd.addr + 16'h0001] <= cmd.wdata[7:0];
            end else if (cmd.we) begin
                mem[cmd.addr] <= cmd.wdata[7:0];
            end else if (cmd.word) begin
                rdata <= {mem[cmd.addr], mem[cmd.addr + 16'h0001]};
            end else begin
                rdata <= {8'h00, mem[cmd.addr]};
            end
        end
    end
endmodule

// *** etdt_params.svh ***
// Functional notes
// RL1: normal mode moves exactly one byte or one word per activation.
// RL2: normal count covers 1 to 65,536 transfers; zero stands for 65,536.
// RL3: when the count expires the request may go on to the cpu.
// RL4: each unit is read at the source word and written at the destination word.
// RL5: normal mode counts in count word a and ignores count word b.
// RL6: source mode 00 keeps the source fixed, 10 increments it.
// RL7: destination mode 10 increments the destination after each unit.
// RL8: transfer mode 00 is normal, 10 is block transfer.
// RL9: size bit 0 moves bytes, 1 moves words.
// RL10: chain and interrupt-select both zero give one transfer per activation.
// RL11: block area select has no effect in normal mode.
// RL12: activation fetches the info start address from the source's vector.
// RL13: a source is served only while its activation enable bit is one.
// RL14: incrementing destination advances by unit size; count drops by one.
// RL15: a transfer that is not the last clears the source's request flag (code keeps it and holds the source when interrupt-select is one).
// RL16: at count zero keep flag, clear enable bit, pass request to cpu.
// RL17: block mode: count a holds block size twice, count b the blocks left.
// RL18: software checks the activation bit is zero before a software request.
// RL19: updated words are written back before the next activation is taken.
`ifndef ETDT_PARAMS_SVH
`define ETDT_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define ETDT_OFS_ENABLE 8'h00
`define ETDT_OFS_SWVEC 8'h04
`define ETDT_OFS_STATUS 8'h08
`define ETDT_OFS_MASK 8'h0C
`define ETDT_OFS_STATE 8'h10
`define ETDT_ENABLE_RST 8'h00
`define ETDT_SWVEC_RST 8'h00
`define ETDT_STATUS_RST 2'h0
`define ETDT_MASK_RST 2'h0
`define ETDT_SWVEC_GO 7
`define ETDT_ST_DONE_BIT 0
`define ETDT_ST_END_BIT 1
// ****************************************
// vectors and register information
// ****************************************
`define ETDT_VEC_BASE 16'h0400
`define ETDT_SRC_VEC_BASE 7'h20
`define ETDT_INFO_LAST 3'h4
`define ETDT_INFO_SAR 3'h1
// ****************************************
// mode word fields (mode_word_a high byte, mode_word_b low byte)
// ****************************************
`define ETDT_SM_HI 7
`define ETDT_SM_LO 6
`define ETDT_DM_HI 5
`define ETDT_DM_LO 4
`define ETDT_MD_HI 3
`define ETDT_MD_LO 2
`define ETDT_DTS 1
`define ETDT_SZ 0
`define ETDT_CHAIN 7
`define ETDT_IRQ_EACH 6
`define ETDT_MD_BLOCK 2'h2
`define ETDT_AM_INC 2'h2
`define ETDT_AM_DEC 2'h3
`endif

// *** etdt_pkg.sv ***
package etdt_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_VEC = 7'h02,
        ST_INFO = 7'h04,
        ST_RD = 7'h08,
        ST_WR = 7'h10,
        ST_WB = 7'h20,
        ST_DONE = 7'h40
    } etdt_state_t;
    typedef struct packed {
        logic [7:0] mode_word_a;
        logic [7:0] mode_word_b;
        logic [15:0] source_address_word;
        logic [15:0] destination_address_word;
        logic [15:0] transfer_count_a;
        logic [15:0] transfer_count_b;
    } etdt_info_t;
    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } etdt_mem_cmd_t;
endpackage

// *** etdt_src_pick.sv ***
`include "etdt_params.svh"
module etdt_src_pick (
    input wire logic [7:0] req,
    output logic valid,
    output logic [2:0] idx
);
    // lowest index wins, matching the fixed default priority
    always_comb begin
        valid = 1'b0;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule

// *** etdt_transfer_controller.sv ***
`include "etdt_params.svh"
module etdt_transfer_controller (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] src_req,
    output logic [7:0] src_flag_clr,
    output logic [7:0] cpu_irq_req,
    output etdt_pkg::etdt_mem_cmd_t mem_cmd,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    output logic irq
);
    import etdt_pkg::*;

    // ****************************************
    // state
    // ****************************************
    etdt_state_t state, next_state;
    etdt_info_t info, next_info, step_info;
    etdt_mem_cmd_t next_mem_cmd;
    logic [2:0] wcnt, next_wcnt;
    logic [2:0] src_sel, next_src_sel;
    logic sw_act, next_sw_act;
    logic last_seen, next_last_seen;
    logic [15:0] info_base, next_info_base;
    logic [15:0] data_buf, next_data_buf;
    logic [7:0] enable, next_enable;
    logic [7:0] swvec, next_swvec;
    logic [7:0] hold, next_hold;
    logic [1:0] status, next_status;
    logic [1:0] mask, next_mask;
    logic [7:0] next_src_flag_clr, next_cpu_irq_req;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic pick_valid, blk_end, step_last, acc, more;
    logic [2:0] pick_idx;
    logic [15:0] vec_addr;
    logic [1:0] st_set, st_clr;

    function automatic etdt_mem_cmd_t mem_op(input logic we, input logic word,
                                             input logic [15:0] a, input logic [15:0] d);
        mem_op.req = 1'b1;
        mem_op.we = we;
        mem_op.word = word;
        mem_op.addr = a;
        mem_op.wdata = d;
    endfunction

    function automatic logic [15:0] info_word(input etdt_info_t f, input logic [2:0] i);
        unique case (i)
            3'h0: info_word = {f.mode_word_a, f.mode_word_b};
            3'h1: info_word = f.source_address_word;
            3'h2: info_word = f.destination_address_word;
            3'h3: info_word = f.transfer_count_a;
            default: info_word = f.transfer_count_b;
        endcase
    endfunction

    etdt_src_pick u_pick (
        .req(src_req & enable & ~hold), // [RL13]
        .valid(pick_valid),
        .idx(pick_idx)
    );

    etdt_unit_step u_step (
        .cur(info),
        .nxt(step_info),
        .blk_end(blk_end),
        .last(step_last)
    );

    // ****************************************
    // next values
    // ****************************************
    always_comb begin
        next_state = state;
        next_info = info;
        next_mem_cmd = mem_cmd;
        next_wcnt = wcnt;
        next_src_sel = src_sel;
        next_sw_act = sw_act;
        next_last_seen = last_seen;
        next_info_base = info_base;
        next_data_buf = data_buf;
        next_enable = enable;
        next_swvec = swvec;
        next_hold = hold & src_req;
        next_src_flag_clr = 8'h00;
        st_set = 2'h0;
        st_clr = 2'h0;
        acc = psel & penable & pready;
        more = 1'b0;
        // requests that the controller is not serving go straight to the cpu
        next_cpu_irq_req = src_req & (~enable | hold); // [RL3] [RL16]
        if (pick_valid) begin
            vec_addr = `ETDT_VEC_BASE + {8'h00, `ETDT_SRC_VEC_BASE + {4'h0, pick_idx}, 1'b0};
        end else begin
            vec_addr = `ETDT_VEC_BASE + {8'h00, swvec[6:0], 1'b0};
        end

        unique case (state)
            ST_IDLE: begin
                // hardware sources take priority over a software request
                if (pick_valid || swvec[`ETDT_SWVEC_GO]) begin
                    next_src_sel = pick_idx;
                    next_sw_act = ~pick_valid;
                    next_mem_cmd = mem_op(1'b0, 1'b1, vec_addr, 16'h0000); // [RL12]
                    next_state = ST_VEC;
                end
            end
            ST_VEC: begin
                if (mem_ack) begin
                    next_info_base = mem_rdata;
                    next_wcnt = 3'h0;
                    next_mem_cmd = mem_op(1'b0, 1'b1, mem_rdata, 16'h0000);
                    next_state = ST_INFO;
                end
            end
            ST_INFO: begin
                if (mem_ack) begin
                    unique case (wcnt)
                        3'h0: {next_info.mode_word_a, next_info.mode_word_b} = mem_rdata;
                        3'h1: next_info.source_address_word = mem_rdata;
                        3'h2: next_info.destination_address_word = mem_rdata;
                        3'h3: next_info.transfer_count_a = mem_rdata;
                        default: next_info.transfer_count_b = mem_rdata;
                    endcase
                    if (wcnt == `ETDT_INFO_LAST) begin
                        next_mem_cmd = mem_op(1'b0, info.mode_word_a[`ETDT_SZ], info.source_address_word, 16'h0000); // [RL4]
                        next_state = ST_RD;
                    end else begin
                        next_wcnt = wcnt + 3'h1;
                        next_mem_cmd = mem_op(1'b0, 1'b1,
                                              info_base + {12'h000, wcnt + 3'h1, 1'b0}, 16'h0000);
                    end
                end
            end
            ST_RD: begin
                if (mem_ack) begin
                    next_data_buf = mem_rdata;
                    next_mem_cmd = mem_op(1'b1, info.mode_word_a[`ETDT_SZ], info.destination_address_word, mem_rdata); // [RL4]
                    next_state = ST_WR;
                end
            end
            ST_WR: begin
                if (mem_ack) begin
                    next_info = step_info; // [RL14]
                    next_last_seen = step_last;
                    // block mode runs the whole block; normal mode stops after one unit
                    more = ({info.mode_word_a[`ETDT_MD_HI], info.mode_word_a[`ETDT_MD_LO]} == `ETDT_MD_BLOCK)
                           && !blk_end; // [RL1] [RL8]
                    if (more) begin
                        next_mem_cmd = mem_op(1'b0, info.mode_word_a[`ETDT_SZ], step_info.source_address_word, 16'h0000);
                        next_state = ST_RD;
                    end else begin
                        next_wcnt = `ETDT_INFO_SAR;
                        next_mem_cmd = mem_op(1'b1, 1'b1, info_base + 16'h0002,
                                              step_info.source_address_word); // [RL19]
                        next_state = ST_WB;
                    end
                end
            end
            ST_WB: begin
                if (mem_ack) begin
                    if (wcnt == `ETDT_INFO_LAST) begin
                        next_mem_cmd = '0;
                        next_state = ST_DONE;
                        st_set[`ETDT_ST_DONE_BIT] = 1'b1;
                        if (sw_act) begin
                            next_swvec[`ETDT_SWVEC_GO] = 1'b0;
                        end
                        if (last_seen) begin
                            // flag stays set so the cpu takes the final request
                            st_set[`ETDT_ST_END_BIT] = 1'b1;
                            if (!sw_act) begin
                                next_enable[src_sel] = 1'b0; // [RL16]
                            end
                        end else if (!sw_act && info.mode_word_b[`ETDT_IRQ_EACH]) begin
                            next_hold[src_sel] = 1'b1;
                        end else if (!sw_act) begin
                            next_src_flag_clr[src_sel] = 1'b1; // [RL15] [RL10]
                        end
                    end else begin
                        next_wcnt = wcnt + 3'h1;
                        next_mem_cmd = mem_op(1'b1, 1'b1,
                                              info_base + {12'h000, wcnt + 3'h1, 1'b0},
                                              info_word(info, wcnt + 3'h1)); // [RL19]
                    end
                end
            end
            ST_DONE: begin
                // one spare cycle lets the cleared flag drop before the next pick
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
                next_mem_cmd = '0;
            end
        endcase

        // apb slave: one wait state, then pready with data
        next_pready = psel & penable & ~pready;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel && penable && !pready) begin
            next_pslverr = 1'b0;
            unique case (paddr)
                `ETDT_OFS_ENABLE: next_prdata = {24'h000000, enable};
                `ETDT_OFS_SWVEC: next_prdata = {24'h000000, swvec};
                `ETDT_OFS_STATUS: next_prdata = {30'h00000000, status};
                `ETDT_OFS_MASK: next_prdata = {30'h00000000, mask};
                `ETDT_OFS_STATE: next_prdata = {21'h000000, src_sel, 1'b0, state};
                default: begin
                    next_prdata = 32'h00000000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
        next_mask = mask;
        if (acc && pwrite) begin
            unique case (paddr)
                `ETDT_OFS_ENABLE: next_enable = pwdata[7:0];
                `ETDT_OFS_SWVEC: next_swvec = pwdata[7:0]; // [RL18]
                `ETDT_OFS_MASK: next_mask = pwdata[1:0];
                default: next_mask = mask;
            endcase
        end
        if (acc && !pwrite && paddr == `ETDT_OFS_STATUS) begin
            st_clr = 2'h3;
        end
        // a new event in the read cycle survives the clear
        next_status = (status & ~st_clr) | st_set;
        next_irq = |(next_status & next_mask);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            info <= '0;
            mem_cmd <= '0;
            wcnt <= 3'h0;
            src_sel <= 3'h0;
            sw_act <= 1'b0;
            last_seen <= 1'b0;
            info_base <= 16'h0000;
            data_buf <= 16'h0000;
            enable <= `ETDT_ENABLE_RST;
            swvec <= `ETDT_SWVEC_RST;
            hold <= 8'h00;
            status <= `ETDT_STATUS_RST;
            mask <= `ETDT_MASK_RST;
            src_flag_clr <= 8'h00;
            cpu_irq_req <= 8'h00;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            state <= next_state;
            info <= next_info;
            mem_cmd <= next_mem_cmd;
            wcnt <= next_wcnt;
            src_sel <= next_src_sel;
            sw_act <= next_sw_act;
            last_seen <= next_last_seen;
            info_base <= next_info_base;
            data_buf <= next_data_buf;
            enable <= next_enable;
            swvec <= next_swvec;
            hold <= next_hold;
            status <= next_status;
            mask <= next_mask;
            src_flag_clr <= next_src_flag_clr;
            cpu_irq_req <= next_cpu_irq_req;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_unit_done;
        state == ST_WR && mem_ack;
    endsequence
    sequence s_finish;
        state == ST_WB && mem_ack && wcnt == `ETDT_INFO_LAST && !sw_act;
    endsequence

    property p_one_unit;
        s_unit_done ##0 (info.mode_word_a[3:2] == 2'h0) |=> state == ST_WB;
    endproperty
    a_one_unit: assert property (p_one_unit) else $error("normal mode moved more than one unit"); // [RL1]

    property p_count_dec;
        s_unit_done ##0 (info.mode_word_a[3:2] == 2'h0) |=> info.transfer_count_a == $past(info.transfer_count_a) - 16'h0001;
    endproperty
    a_count_dec: assert property (p_count_dec) else $error("count not decremented"); // [RL14]

    property p_dst_inc;
        s_unit_done ##0 (info.mode_word_a[5:4] == 2'h2)
            |=> info.destination_address_word == $past(info.destination_address_word) + ($past(info.mode_word_a[0]) ? 16'h0002 : 16'h0001);
    endproperty
    a_dst_inc: assert property (p_dst_inc) else $error("destination step wrong"); // [RL7]

    property p_src_fixed;
        s_unit_done ##0 (info.mode_word_a[7:6] == 2'h0) |=> $stable(info.source_address_word);
    endproperty
    a_src_fixed: assert property (p_src_fixed) else $error("fixed source moved"); // [RL6]

    property p_gate;
        state == ST_IDLE && !swvec[7] && (src_req & enable & ~hold) == 8'h00 |=> state == ST_IDLE;
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source activated"); // [RL13]

    property p_last;
        s_finish ##0 last_seen |=> !enable[$past(src_sel)] ##1 src_flag_clr == 8'h00;
    endproperty
    a_last: assert property (p_last) else $error("final transfer mishandled"); // [RL16]

    property p_clr_flag;
        s_finish ##0 (!last_seen && !info.mode_word_b[6])
            |=> src_flag_clr == (8'h01 << $past(src_sel)) && state == ST_DONE;
    endproperty
    a_clr_flag: assert property (p_clr_flag) else $error("request flag not cleared"); // [RL15]

    property p_vector;
        state == ST_IDLE && next_state == ST_VEC |=> mem_cmd.req && !mem_cmd.we
            && mem_cmd.addr == ($past(pick_valid) ? 16'h0440 + {12'h000, $past(pick_idx), 1'b0}
            : 16'h0400 + {8'h00, $past(swvec[6:0]), 1'b0});
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong"); // [RL12]

    property p_src_read;
        state == ST_INFO && next_state == ST_RD |=> !mem_cmd.we && mem_cmd.addr == info.source_address_word;
    endproperty
    a_src_read: assert property (p_src_read) else $error("source read address wrong"); // [RL4]

    property p_writeback;
        s_unit_done ##0 (next_state == ST_WB)
            |=> mem_cmd.we && mem_cmd.addr == info_base + 16'h0002 ##1 state == ST_WB;
    endproperty
    a_writeback: assert property (p_writeback) else $error("write-back not started"); // [RL19]
endmodule

// *** etdt_transfer_controller_bench.sv ***
module etdt_transfer_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import etdt_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, mem_ack, irq, err;
    logic [7:0] paddr, src_req, src_flag_clr, cpu_irq_req;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] mem_rdata;
    logic [1:0] mdly;
    etdt_mem_cmd_t mem_cmd;
    int fails, checks, cyc, clrs;
    etdt_transfer_controller etdt_transfer_controller_inst (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .src_flag_clr(src_flag_clr), .cpu_irq_req(cpu_irq_req), .mem_cmd(mem_cmd),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
    etdt_mem_model etdt_mem_model_inst (.clk(clk), .sys_rst(sys_rst), .cmd(mem_cmd),
        .delay(mdly), .rdata(mem_rdata), .ack(mem_ack));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // ****************************************
    // peripheral flag and watchdog
    // ****************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (src_flag_clr !== 8'h00) begin
            src_req <= src_req & ~src_flag_clr;
            clrs <= clrs + 1;
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            complete_run();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task complete_run;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    task mw(input logic [15:0] a, input logic [15:0] w);
        etdt_mem_model_inst.mem[a] = w[15:8];
        etdt_mem_model_inst.mem[a + 16'h0001] = w[7:0];
    endtask
    function automatic logic [31:0] mr(input logic [15:0] a);
        return {16'h0000, etdt_mem_model_inst.mem[a], etdt_mem_model_inst.mem[a + 16'h0001]};
    endfunction
    task info(input logic [15:0] v, b, input logic [7:0] m, input logic [15:0] s, d, ca, cb);
        mw(v, b);
        mw(b, {m, 8'h00});
        mw(b + 16'h0002, s);
        mw(b + 16'h0004, d);
        mw(b + 16'h0006, ca);
        mw(b + 16'h0008, cb);
    endtask
    // fixed 4-cycle wait, then polling: no fixed latency is assumed for an activation
    task wait_idle;
        repeat (4) @(posedge clk);
        do begin
            apb(1'h0, 8'h10, 32'h0);
        end while (rd[6:0] !== 7'h01);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata, src_req, mdly} = '0;
        sys_rst = 1'h1;
        {fails, checks, cyc, clrs} = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        rdchk(8'h00, 32'h0);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        rdchk(8'h10, 32'h1);
        apb(1'h0, 8'h14, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'h1, 8'h0C, 32'h3);
        rdchk(8'h0C, 32'h3);
        $display("test registers done");
        info(16'h0440, 16'h1000, 8'h22, 16'h3000, 16'h2000, 16'h0002, 16'hBEEF);
        mw(16'h3000, 16'h5A77);
        src_req <= 8'h01;
        repeat (10) @(posedge clk);
        rdchk(8'h10, 32'h1);
        apb(1'h1, 8'h00, 32'h1);
        wait_idle();
        chk(mr(16'h2000) >> 8, 32'h5A);
        chk(mr(16'h1002), 32'h3000);
        chk(mr(16'h1004), 32'h2001);
        chk(mr(16'h1006), 32'h1);
        chk(mr(16'h1008), 32'hBEEF);
        chk(32'(clrs), 32'h1);
        chk(32'(cpu_irq_req), 32'h0);
        mw(16'h3000, 16'hA577);
        src_req <= 8'h01;
        wait_idle();
        chk(mr(16'h2000), 32'h5AA5);
        chk(mr(16'h1006), 32'h0);
        chk(32'(clrs), 32'h1);
        rdchk(8'h00, 32'h0);
        chk(32'(cpu_irq_req), 32'h1);
        chk(32'(irq), 32'h1);
        rdchk(8'h08, 32'h3);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        src_req <= 8'h00;
        $display("test normal done");
        mdly <= 2'h2;
        info(16'h04C0, 16'h1100, 8'hA9, 16'h3000, 16'h2100, 16'h0202, 16'h0001);
        mw(16'h3000, 16'h1122);
        mw(16'h3002, 16'h3344);
        apb(1'h0, 8'h04, 32'h0);
        chk(32'(rd[7]), 32'h0);
        apb(1'h1, 8'h04, 32'hE0);
        wait_idle();
        chk(mr(16'h2100), 32'h1122);
        chk(mr(16'h2102), 32'h3344);
        chk(mr(16'h1102), 32'h3004);
        chk(mr(16'h1104), 32'h2104);
        chk(mr(16'h1108), 32'h0);
        rdchk(8'h04, 32'h60);
        chk(32'(clrs), 32'h1);
        $display("test block done");
        // source 1, decrementing destination, interrupt-each: flag kept, source held
        info(16'h0442, 16'h1200, 8'h30, 16'h3000, 16'h2200, 16'h0005, 16'h0000);
        mw(16'h1200, 16'h3040);
        src_req <= 8'h02;
        apb(1'h1, 8'h00, 32'h2);
        wait_idle();
        chk(mr(16'h2200) >> 8, 32'h11);
        chk(mr(16'h1204), 32'h21FF);
        chk(mr(16'h1206), 32'h4);
        chk(32'(clrs), 32'h1);
        chk(32'(cpu_irq_req), 32'h2);
        src_req <= 8'h00;
        $display("test hold done");
        complete_run();
    end
endmodule

// *** etdt_unit_step.sv ***
`include "etdt_params.svh"
module etdt_unit_step (
    input etdt_pkg::etdt_info_t cur,
    output etdt_pkg::etdt_info_t nxt,
    output logic blk_end,
    output logic last
);
    import etdt_pkg::*;
    logic [15:0] sz;
    logic blk;

    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] m,
                                              input logic [15:0] s);
        unique case (m)
            `ETDT_AM_INC: step_addr = a + s;
            `ETDT_AM_DEC: step_addr = a - s;
            default: step_addr = a;
        endcase
    endfunction

    always_comb begin
        sz = cur.mode_word_a[`ETDT_SZ] ? 16'h0002 : 16'h0001; // [RL9]
        blk = ({cur.mode_word_a[`ETDT_MD_HI], cur.mode_word_a[`ETDT_MD_LO]} == `ETDT_MD_BLOCK); // [RL8]
        nxt = cur;
        blk_end = 1'b0;
        last = 1'b0;
        nxt.source_address_word = step_addr(cur.source_address_word, {cur.mode_word_a[`ETDT_SM_HI], cur.mode_word_a[`ETDT_SM_LO]}, sz); // [RL6]
        nxt.destination_address_word = step_addr(cur.destination_address_word, {cur.mode_word_a[`ETDT_DM_HI], cur.mode_word_a[`ETDT_DM_LO]}, sz); // [RL7] [RL14]
        if (blk) begin
            // block size sits in both halves; low half counts, high half reloads
            nxt.transfer_count_a[7:0] = cur.transfer_count_a[7:0] - 8'h01; // [RL17]
            if (nxt.transfer_count_a[7:0] == 8'h00) begin
                blk_end = 1'b1;
                nxt.transfer_count_a[7:0] = cur.transfer_count_a[15:8];
                nxt.transfer_count_b = cur.transfer_count_b - 16'h0001;
                last = (nxt.transfer_count_b == 16'h0000);
            end
        end else begin
            // count b untouched, area select unused here; zero wraps for 65,536
            nxt.transfer_count_a = cur.transfer_count_a - 16'h0001; // [RL5] [RL2] [RL11]
            last = (nxt.transfer_count_a == 16'h0000);
        end
    end
endmodule
